// >>> hdl/cmd_engine_defines.vh
// Constants for the register access command engine.
`ifndef CMD_ENGINE_DEFINES_VH
`define CMD_ENGINE_DEFINES_VH

// ==========================================================================
// Register offsets (9 bits so that incrementing addresses never wrap).
`define ADDR_IDENTITY_HIGH       9'h000
`define ADDR_IDENTITY_LOW        9'h001
`define ADDR_GENERAL_FAULTS      9'h002
`define ADDR_POSITIVE_FAULTS     9'h003
`define ADDR_NEGATIVE_FAULTS     9'h004
`define ADDR_LINK_FAULTS         9'h005
`define ADDR_LINK_ERROR_COUNTER  9'h006
`define ADDR_MODE_PIN_READBACK   9'h007
`define ADDR_ANALOG_SYSTEM_CFG   9'h00B
`define ADDR_DIGITAL_SYSTEM_CFG  9'h00C
`define ADDR_CLOCK_SOURCE_DIV    9'h00D
`define ADDR_MODULATOR_CLOCK     9'h00E
`define ADDR_CHANNEL_ENABLE      9'h00F
`define ADDR_RESERVED_10         9'h010
`define ADDR_CHANNEL1_GAIN       9'h011
`define ADDR_CHANNEL2_GAIN       9'h012
`define ADDR_CHANNEL3_GAIN       9'h013
`define ADDR_CHANNEL4_GAIN       9'h014
`define CFG_BASE                 9'h00B
`define CFG_COUNT                10

// ==========================================================================
// Reset values.
`define RST_ANALOG_SYSTEM_CFG    8'h60
`define RST_DIGITAL_SYSTEM_CFG   8'h3C
`define RST_CLOCK_SOURCE_DIV     8'h08
`define RST_MODULATOR_CLOCK      8'h86
`define RST_ZERO                 8'h00
`define CHANNEL_COUNT_TWO        4'h2
`define CHANNEL_COUNT_FOUR       4'h4

// ==========================================================================
// Command word fields and codes.
`define OP_MSB                   15
`define OP_LSB                   13
`define ADR_MSB                  12
`define ADR_LSB                  8
`define CNT_MSB                  7
`define OP_READ                  3'h1
`define OP_WRITE_SINGLE          3'h2
`define OP_WRITE_MULTI           3'h3
`define RSP_READBACK             3'h1
`define RSP_WRITE_MULTI          3'h2
`define RSP_READ_MULTI           3'h3

// ==========================================================================
// Link word geometry.
`define CMD_BITS                 16
`define CMD_LAST_BIT             5'h0F
`define WLEN_16                  2'h0
`define WLEN_24                  2'h1
`define LAST_BIT_16              5'h0F
`define LAST_BIT_24              5'h17
`define LAST_BIT_32              5'h1F

`endif

// >>> hdl/link_sampler.v
// Two-flop synchroniser and edge finder for the serial link pins.

module link_sampler (
  // Clock and reset
  input  wire ref_clk_in,
  input  wire arst_n_in,
  // Raw link pins
  input  wire sclk_in,
  input  wire cs_n_in,
  input  wire din_in,
  // Synchronised levels and edge pulses
  output reg  frame_active_out,
  output reg  data_out,
  output reg  sclk_rise_out,
  output reg  sclk_fall_out,
  output reg  frame_start_out,
  output reg  frame_end_out
);

  // ========================================================================
  // Synchroniser stages.
  reg  [2:0] meta;
  reg  [2:0] sync;
  reg        sclk_prev;
  reg        act_prev;

  // The first stage feeds only the second; edges compare stages two and
  // three so no logic ever looks at a possibly metastable flop.
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta             <= 3'h0;
      sync             <= 3'h0;
      sclk_prev        <= 1'b0;
      act_prev         <= 1'b0;
      frame_active_out <= 1'b0;
      data_out         <= 1'b0;
      sclk_rise_out    <= 1'b0;
      sclk_fall_out    <= 1'b0;
      frame_start_out  <= 1'b0;
      frame_end_out    <= 1'b0;
    end else begin
      meta             <= {sclk_in, ~cs_n_in, din_in};
      sync             <= meta;
      sclk_prev        <= sync[2];
      act_prev         <= sync[1];
      frame_active_out <= sync[1];
      data_out         <= sync[0];
      sclk_rise_out    <= sync[2] & ~sclk_prev;
      sclk_fall_out    <= ~sync[2] & sclk_prev;
      frame_start_out  <= sync[1] & ~act_prev;
      frame_end_out    <= ~sync[1] & act_prev;
    end
  end

endmodule // link_sampler

// >>> hdl/register_access_command_engine.v
// Register command decoder and register map behind the serial frame link.
//
// Notes on behaviour
// - Multi-read acknowledge is 011, address, count as sent.
// - Read pair word: lower address upper byte.
// - Keep sending pairs over frames until done.
// - Ignore new commands while multi-read response pending.
// - Registers past the map read as zero.
// - Single write answers with readback of new value.
// - Multi-write stores to incrementing consecutive addresses.
// - Multi-write data past the map is dropped.
// - Each data word writes two bytes, upper first; when one byte is left, only the upper byte is written.
// - Only the 16 top bits of a word count.
// - Multi-write acknowledge is 010, address, count plus two.
// - Identity register is fixed, revision and channel count.
// - Channel 3 and 4 gains only on four channels.
// - Readback is 001, address, register contents.
// - Locked link obeys only reads; writes pass on as foreign commands.
// - Command acts at frame end (multi-write data as each word lands), answer next frame.

`include "cmd_engine_defines.vh"

module register_access_command_engine #(
  parameter       CHANNELS = 4,
  // Arbitrary revision code.
  parameter [3:0] REVISION = 4'h1
) (
  // Clock and reset
  input  wire       ref_clk_in,
  input  wire       arst_n_in,
  // Serial link
  input  wire       sclk_in,
  input  wire       cs_n_in,
  input  wire       din_in,
  output reg        dout_out,
  // Settings from neighbouring logic
  input  wire [1:0] word_len_in,
  input  wire       locked_in,
  // Status from neighbouring logic
  input  wire [7:0] general_fault_flags_in,
  input  wire [7:0] positive_input_faults_in,
  input  wire [7:0] negative_input_faults_in,
  input  wire [7:0] link_fault_flags_in,
  input  wire [7:0] link_error_counter_in,
  input  wire [7:0] mode_pin_readback_in,
  // Configuration registers
  output reg  [7:0] analog_system_config_out,
  output reg  [7:0] digital_system_config_out,
  output reg  [7:0] clock_source_divider_out,
  output reg  [7:0] modulator_clock_oversampling_out,
  output reg  [7:0] channel_enable_out,
  output reg  [7:0] channel1_gain_out,
  output reg  [7:0] channel2_gain_out,
  output reg  [7:0] channel3_gain_out,
  output reg  [7:0] channel4_gain_out,
  // Commands left to neighbouring logic
  output reg        foreign_cmd_out,
  output reg [15:0] foreign_word_out
);

  // ========================================================================
  // Link sampling.
  wire        frame_active;
  wire        din_s;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        frame_start;
  wire        frame_end;

  link_sampler u_sampler (
    .ref_clk_in       (ref_clk_in),
    .arst_n_in        (arst_n_in),
    .sclk_in          (sclk_in),
    .cs_n_in          (cs_n_in),
    .din_in           (din_in),
    .frame_active_out (frame_active),
    .data_out         (din_s),
    .sclk_rise_out    (sclk_rise),
    .sclk_fall_out    (sclk_fall),
    .frame_start_out  (frame_start),
    .frame_end_out    (frame_end)
  );

  // ========================================================================
  // State.
  reg  [7:0]  cfg [0:`CFG_COUNT-1];
  reg  [31:0] tx_shift;
  reg  [15:0] rx_shift;
  reg  [15:0] resp_word;
  reg  [15:0] cmd_word;
  reg         have_cmd;
  reg         first_word;
  reg  [4:0]  bit_cnt;
  reg         rd_busy;
  reg  [8:0]  rd_addr;
  reg  [8:0]  rd_left;
  reg         mw_on;
  reg  [8:0]  mw_addr;
  reg  [8:0]  mw_left;
  integer     i;

  wire [15:0] rx_word = {rx_shift[14:0], din_s};
  wire [2:0]  cmd_op  = cmd_word[`OP_MSB:`OP_LSB];
  wire [4:0]  cmd_adr = cmd_word[`ADR_MSB:`ADR_LSB];
  wire [7:0]  cmd_cnt = cmd_word[`CNT_MSB:0];
  wire [2:0]  rx_op   = rx_word[`OP_MSB:`OP_LSB];

  // ========================================================================
  // Map functions.
  function [4:0] last_bit;
    input [1:0] sel;
    begin
      case (sel)
        `WLEN_16: last_bit = `LAST_BIT_16;
        `WLEN_24: last_bit = `LAST_BIT_24;
        default:  last_bit = `LAST_BIT_32;
      endcase
    end
  endfunction

  function writable;
    input [8:0] adr;
    begin
      writable = ((adr >= `ADDR_ANALOG_SYSTEM_CFG) &&
                  (adr <= `ADDR_CHANNEL_ENABLE)) ||
                 (adr == `ADDR_CHANNEL1_GAIN) ||
                 (adr == `ADDR_CHANNEL2_GAIN) ||
                 (((adr == `ADDR_CHANNEL3_GAIN) ||
                   (adr == `ADDR_CHANNEL4_GAIN)) && (CHANNELS == 4));
    end
  endfunction

  function [7:0] reset_value;
    input integer idx;
    begin
      case (idx)
        0:       reset_value = `RST_ANALOG_SYSTEM_CFG;
        1:       reset_value = `RST_DIGITAL_SYSTEM_CFG;
        2:       reset_value = `RST_CLOCK_SOURCE_DIV;
        3:       reset_value = `RST_MODULATOR_CLOCK;
        default: reset_value = `RST_ZERO;
      endcase
    end
  endfunction

  function [7:0] reg_read;
    input [8:0] adr;
    reg   [8:0] idx;
    begin
      idx = adr - `CFG_BASE;
      case (adr)
        `ADDR_IDENTITY_HIGH:
          reg_read = {REVISION, (CHANNELS == 4) ? `CHANNEL_COUNT_FOUR :
                                   `CHANNEL_COUNT_TWO};
        `ADDR_GENERAL_FAULTS:     reg_read = general_fault_flags_in;
        `ADDR_POSITIVE_FAULTS:    reg_read = positive_input_faults_in;
        `ADDR_NEGATIVE_FAULTS:    reg_read = negative_input_faults_in;
        `ADDR_LINK_FAULTS:        reg_read = link_fault_flags_in;
        `ADDR_LINK_ERROR_COUNTER: reg_read = link_error_counter_in;
        `ADDR_MODE_PIN_READBACK:  reg_read = mode_pin_readback_in;
        default:
          // Reserved and nonexistent addresses read zero.
          reg_read = writable(adr) ? cfg[idx[3:0]] : `RST_ZERO;
      endcase
    end
  endfunction

  // ========================================================================
  // Write ports: at most two bytes land in one cycle.
  reg         we_a;
  reg         we_b;
  reg  [8:0]  wa_a;
  reg  [8:0]  wa_b;
  reg  [7:0]  wd_a;
  reg  [7:0]  wd_b;
  reg  [8:0]  wi_a;
  reg  [8:0]  wi_b;

  wire take_word = frame_active & sclk_fall & (bit_cnt == `CMD_LAST_BIT);
  wire single_ok = have_cmd & ~rd_busy & ~locked_in &
                   (cmd_op == `OP_WRITE_SINGLE);

  always @* begin
    we_a = 1'b0;
    we_b = 1'b0;
    wa_a = {4'h0, cmd_adr};
    wa_b = mw_addr + 9'h001;
    wd_a = cmd_cnt;
    wd_b = rx_word[7:0];
    if (frame_end && single_ok) begin
      we_a = writable(wa_a);
    end else if (take_word && !first_word && mw_on) begin
      wa_a = mw_addr;
      wd_a = rx_word[15:8];
      we_a = writable(wa_a);
      we_b = writable(wa_b) && (mw_left > 9'h001);
    end
    wi_a = wa_a - `CFG_BASE;
    wi_b = wa_b - `CFG_BASE;
  end

  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (i = 0; i < `CFG_COUNT; i = i + 1) begin
        cfg[i] <= reset_value(i);
      end
    end else begin
      if (we_a) begin
        cfg[wi_a[3:0]] <= wd_a;
      end
      if (we_b) begin
        cfg[wi_b[3:0]] <= wd_b;
      end
    end
  end

  // ========================================================================
  // Frame engine: shifting, word capture, decode at frame end.
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_shift         <= 32'h00000000;
      rx_shift         <= 16'h0000;
      resp_word        <= 16'h0000;
      cmd_word         <= 16'h0000;
      have_cmd         <= 1'b0;
      first_word       <= 1'b1;
      bit_cnt          <= 5'h00;
      rd_busy          <= 1'b0;
      rd_addr          <= 9'h000;
      rd_left          <= 9'h000;
      mw_on            <= 1'b0;
      mw_addr          <= 9'h000;
      mw_left          <= 9'h000;
      dout_out         <= 1'b0;
      foreign_cmd_out  <= 1'b0;
      foreign_word_out <= 16'h0000;
    end else begin
      foreign_cmd_out <= 1'b0;
      if (frame_start) begin
        // The answer sits in the top 16 bits of the first word.
        tx_shift   <= {resp_word, 16'h0000};
        dout_out   <= 1'b0;
        bit_cnt    <= 5'h00;
        first_word <= 1'b1;
        have_cmd   <= 1'b0;
        mw_on      <= 1'b0;
      end
      if (frame_active && sclk_rise) begin
        dout_out <= tx_shift[31];
        tx_shift <= {tx_shift[30:0], 1'b0};
      end
      if (frame_active && sclk_fall) begin
        if (bit_cnt < `CMD_BITS) begin
          rx_shift <= rx_word;
        end
        if (bit_cnt == last_bit(word_len_in)) begin
          bit_cnt    <= 5'h00;
          first_word <= 1'b0;
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
      if (take_word && first_word) begin
        cmd_word <= rx_word;
        have_cmd <= 1'b1;
        // Later words of a multi-write carry data, not commands.
        if ((rx_op == `OP_WRITE_MULTI) && !rd_busy && !locked_in) begin
          mw_on   <= 1'b1;
          mw_addr <= {4'h0, rx_word[`ADR_MSB:`ADR_LSB]};
          mw_left <= {1'b0, rx_word[`CNT_MSB:0]} + 9'h001;
        end
      end else if (take_word && mw_on) begin
        mw_addr <= mw_addr + 9'h002;
        if (mw_left > 9'h002) begin
          mw_left <= mw_left - 9'h002;
        end else begin
          mw_on   <= 1'b0;
          mw_left <= 9'h000;
        end
      end
      if (frame_end) begin
        if (rd_busy) begin
          // Commands of this frame are dropped while pairs remain.
          resp_word <= {reg_read(rd_addr),
                        (rd_left > 9'h001) ? reg_read(rd_addr + 9'h001) :
                                             `RST_ZERO};
          rd_addr   <= rd_addr + 9'h002;
          if (rd_left > 9'h002) begin
            rd_left <= rd_left - 9'h002;
          end else begin
            rd_left <= 9'h000;
            rd_busy <= 1'b0;
          end
        end else if (!have_cmd) begin
          resp_word <= 16'h0000;
        end else begin
          case (cmd_op)
            `OP_READ: begin
              if (cmd_cnt == 8'h00) begin
                resp_word <= {`RSP_READBACK, cmd_adr,
                              reg_read({4'h0, cmd_adr})};
              end else begin
                resp_word <= {`RSP_READ_MULTI, cmd_adr, cmd_cnt};
                rd_busy   <= 1'b1;
                rd_addr   <= {4'h0, cmd_adr};
                rd_left   <= {1'b0, cmd_cnt} + 9'h001;
              end
            end
            `OP_WRITE_SINGLE: begin
              if (locked_in) begin
                resp_word        <= 16'h0000;
                foreign_cmd_out  <= 1'b1;
                foreign_word_out <= cmd_word;
              end else begin
                resp_word <= {`RSP_READBACK, cmd_adr,
                              writable(wa_a) ? cmd_cnt :
                                reg_read(wa_a)};
              end
            end
            `OP_WRITE_MULTI: begin
              if (locked_in) begin
                resp_word        <= 16'h0000;
                foreign_cmd_out  <= 1'b1;
                foreign_word_out <= cmd_word;
              end else begin
                resp_word <= {`RSP_WRITE_MULTI, cmd_adr,
                              cmd_cnt + 8'h02};
              end
            end
            default: begin
              resp_word        <= 16'h0000;
              foreign_cmd_out  <= 1'b1;
              foreign_word_out <= cmd_word;
            end
          endcase
        end
      end
    end
  end

  // ========================================================================
  // Configuration outputs, each straight from its flop.
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      analog_system_config_out         <= `RST_ANALOG_SYSTEM_CFG;
      digital_system_config_out        <= `RST_DIGITAL_SYSTEM_CFG;
      clock_source_divider_out         <= `RST_CLOCK_SOURCE_DIV;
      modulator_clock_oversampling_out <= `RST_MODULATOR_CLOCK;
      channel_enable_out               <= `RST_ZERO;
      channel1_gain_out                <= `RST_ZERO;
      channel2_gain_out                <= `RST_ZERO;
      channel3_gain_out                <= `RST_ZERO;
      channel4_gain_out                <= `RST_ZERO;
    end else begin
      // One cycle behind the map, so outputs stay flop-driven.
      analog_system_config_out         <= cfg[0];
      digital_system_config_out        <= cfg[1];
      clock_source_divider_out         <= cfg[2];
      modulator_clock_oversampling_out <= cfg[3];
      channel_enable_out               <= cfg[4];
      channel1_gain_out                <= cfg[6];
      channel2_gain_out                <= cfg[7];
      channel3_gain_out                <= cfg[8];
      channel4_gain_out                <= cfg[9];
    end
  end

endmodule // register_access_command_engine

// >>> dv/cmd_engine_sva.sv
// Port-level assertions for the register access command engine.
module cmd_engine_sva #(
  parameter CHANNELS = 4
) (
  // Clock, reset and link
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic        sclk_in,
  input wire logic        cs_n_in,
  input wire logic        dout_out,
  input wire logic        locked_in,
  // Register outputs
  input wire logic [7:0]  analog_system_config_out,
  input wire logic [7:0]  digital_system_config_out,
  input wire logic [7:0]  clock_source_divider_out,
  input wire logic [7:0]  modulator_clock_oversampling_out,
  input wire logic [7:0]  channel_enable_out,
  input wire logic [7:0]  channel1_gain_out,
  input wire logic [7:0]  channel2_gain_out,
  input wire logic [7:0]  channel3_gain_out,
  input wire logic [7:0]  channel4_gain_out,
  // Commands passed on
  input wire logic        foreign_cmd_out,
  input wire logic [15:0] foreign_word_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Helper history of the asynchronous link pins
  logic [5:0]  sclk_hist;
  logic [7:0]  cs_hist;
  logic [3:0]  idle_cnt;
  wire  [71:0] cfg_all = {analog_system_config_out, digital_system_config_out,
    clock_source_divider_out, modulator_clock_oversampling_out,
    channel_enable_out, channel1_gain_out, channel2_gain_out,
    channel3_gain_out, channel4_gain_out};
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_hist <= 6'h00;
      cs_hist   <= 8'hFF;
      idle_cnt  <= 4'h0;
    end else begin
      sclk_hist <= {sclk_hist[4:0], sclk_in};
      cs_hist   <= {cs_hist[6:0], cs_n_in};
      if (!cs_n_in) begin
        idle_cnt <= 4'h0;
      end else if (idle_cnt != 4'hF) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_reset_values: assert property ($rose(arst_n_in) |->
    {analog_system_config_out, digital_system_config_out,
     clock_source_divider_out, modulator_clock_oversampling_out,
     channel_enable_out} == 40'h603C088600)
    else $error("config outputs wrong after reset");
  a_foreign_pulse: assert property (foreign_cmd_out |=> !foreign_cmd_out)
    else $error("foreign pulse longer than one cycle");
  a_foreign_word_hold: assert property ($changed(foreign_word_out) |-> foreign_cmd_out)
    else $error("foreign word changed without pulse");
  a_foreign_at_end: assert property (foreign_cmd_out |-> |cs_hist)
    else $error("foreign pulse away from frame end");
  a_dout_after_edge: assert property ($changed(dout_out) |-> (|sclk_hist) || (|cs_hist))
    else $error("dout changed without link edge");
  a_cfg_after_frame: assert property ($changed(cfg_all) |-> idle_cnt < 4'hA)
    else $error("register changed long after frame");
  a_cfg_when_locked: assert property ($changed(cfg_all) |-> !$past(locked_in))
    else $error("register written while locked");
  a_gain_variant: assert property ($changed(channel3_gain_out) ||
    $changed(channel4_gain_out) |-> CHANNELS == 4)
    else $error("upper gains written on two channels");
endmodule // cmd_engine_sva

// >>> dv/host_link_model.sv
// Host controller model that sends command frames on the serial link.
module host_link_model (
  // Link pins driven by the host
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  // Device answer
  input  wire logic dout_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // ==========================================================================
  // Frame driver
  // The clock stands low between frames; data moves on the rising edge so
  // the device, sampling on falling edges, always sees a settled bit.
  task automatic xfer(input logic [47:0] ws, input int nw, input int bits,
                      output logic [15:0] first);
    logic [31:0] sh;
    first = 16'h0000;
    cs_n_out = 1'b0;
    #100;
    for (int k = 0; k < nw; k++) begin
      // Bits below the top sixteen carry junk that must not matter.
      sh = {ws[47 - 16 * k -: 16], 16'hA5C3};
      for (int i = 0; i < bits; i++) begin
        sclk_out = 1'b1;
        din_out  = sh[31 - i];
        #62.5;
        if (k == 0 && i < 16) first[15 - i] = dout_in;
        sclk_out = 1'b0;
        #62.5;
      end
    end
    #100;
    cs_n_out = 1'b1;
    din_out  = ~din_out;
    #100;
  endtask
endmodule // host_link_model

// >>> dv/tb.sv
// Self-checking bench for the register access command engine.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CHANNELS = 4;
  // Arbitrary revision code.
  localparam logic [3:0] REV = 4'h7;
  logic        ref_clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  wire         sclk_in;
  wire         cs_n_in;
  wire         din_in;
  wire         dout_out;
  logic [1:0]  word_len_in = 2'h0;
  logic        locked_in = 1'b0;
  logic [7:0]  st [6] = '{8'h12, 8'h23, 8'h34, 8'h45, 8'h56, 8'h67};
  wire  [7:0]  analog_system_config_out, digital_system_config_out;
  wire  [7:0]  clock_source_divider_out, modulator_clock_oversampling_out;
  wire  [7:0]  channel_enable_out, channel1_gain_out, channel2_gain_out;
  wire  [7:0]  channel3_gain_out, channel4_gain_out;
  wire         foreign_cmd_out;
  wire  [15:0] foreign_word_out;
  int          fail_count = 0;
  int          num_checks = 0;
  int          foreign_seen = 0;
  int          bits = 16;
  logic [15:0] r;
  always #5 ref_clk_in = ~ref_clk_in;
  // Counts the one-cycle pulses of commands handed on to neighbours.
  always @(posedge ref_clk_in) begin
    if (foreign_cmd_out === 1'b1) begin
      foreign_seen++;
    end
  end
  register_access_command_engine #(.CHANNELS(CHANNELS), .REVISION(REV))
    register_access_command_engine_i (
    .ref_clk_in, .arst_n_in, .sclk_in, .cs_n_in, .din_in, .dout_out,
    .word_len_in, .locked_in,
    .general_fault_flags_in(st[0]), .positive_input_faults_in(st[1]),
    .negative_input_faults_in(st[2]), .link_fault_flags_in(st[3]),
    .link_error_counter_in(st[4]), .mode_pin_readback_in(st[5]),
    .analog_system_config_out, .digital_system_config_out,
    .clock_source_divider_out, .modulator_clock_oversampling_out,
    .channel_enable_out, .channel1_gain_out, .channel2_gain_out,
    .channel3_gain_out, .channel4_gain_out, .foreign_cmd_out,
    .foreign_word_out);
  host_link_model host_link_model_i (.sclk_out(sclk_in), .cs_n_out(cs_n_in),
    .din_out(din_in), .dout_in(dout_out));
  // ==========================================================================
  // Shared helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic fr(input logic [15:0] w);
    host_link_model_i.xfer({w, 32'h0}, 1, bits, r);
  endtask
  function automatic logic [7:0] exp_reset(input int a);
    case (a)
      0: return {REV, (CHANNELS == 4) ? 4'h4 : 4'h2};
      2, 3, 4, 5, 6, 7: return st[a - 2];
      11: return 8'h60;
      12: return 8'h3C;
      13: return 8'h08;
      14: return 8'h86;
      default: return 8'h00;
    endcase
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset_reads();
    check({analog_system_config_out, digital_system_config_out,
           clock_source_divider_out, modulator_clock_oversampling_out,
           channel_enable_out}, 40'h603C088600);
    check({channel1_gain_out, channel2_gain_out, channel3_gain_out,
           channel4_gain_out}, 32'h00000000);
    fr(16'h2000);
    for (int a = 1; a <= 23; a++) begin
      fr(a < 23 ? {3'h1, a[4:0], 8'h00} : 16'h2000);
      check(r, {3'h1, 5'(a - 1), exp_reset(a - 1)});
    end
  endtask
  task automatic t_write_single();
    fr(16'h4F05);
    fr(16'h4255);
    check(r, 16'h2F05);
    check(channel_enable_out, 8'h05);
    fr(16'h0000);
    check(r, {8'h22, st[0]});
  endtask
  task automatic t_write_multi();
    host_link_model_i.xfer({16'h6B01, 16'h1122, 16'h0000}, 2, bits, r);
    host_link_model_i.xfer({16'h7303, 16'h0102, 16'h0304}, 3, bits, r);
    check(r, 16'h4B03);
    fr(16'h0000);
    check(r, 16'h5305);
    check({analog_system_config_out, digital_system_config_out}, 16'h1122);
    check({channel3_gain_out, channel4_gain_out}, 16'h0102);
    host_link_model_i.xfer({16'h7100, 16'h0607, 16'h0000}, 2, bits, r);
    check({channel1_gain_out, channel2_gain_out}, 16'h0600);
  endtask
  task automatic t_read_multi();
    fr(16'h3302);
    fr(16'h4F0A);
    check(r, 16'h7302);
    fr(16'h0000);
    check(r, 16'h0102);
    fr(16'h2F00);
    check(r, 16'h0000);
    fr(16'h0000);
    check(r, 16'h2F05);
  endtask
  task automatic t_word24();
    @(negedge ref_clk_in) word_len_in = 2'h1;
    bits = 24;
    fr(16'h4E77);
    fr(16'h2E00);
    check(r, 16'h2E77);
    fr(16'h0000);
    check(r, 16'h2E77);
    check(modulator_clock_oversampling_out, 8'h77);
    bits = 16;
    @(negedge ref_clk_in) word_len_in = 2'h0;
  endtask
  task automatic t_locked();
    int n0;
    @(negedge ref_clk_in) locked_in = 1'b1;
    n0 = foreign_seen;
    fr(16'h4F33);
    fr(16'h2F00);
    check(r, 16'h0000);
    check(foreign_seen - n0, 1);
    check(foreign_word_out, 16'h4F33);
    fr(16'h0000);
    check(r, 16'h2F05);
    @(negedge ref_clk_in) locked_in = 1'b0;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    @(negedge ref_clk_in);
    t_reset_reads();
    t_write_single();
    t_write_multi();
    t_read_multi();
    t_word24();
    t_locked();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    fail_count++;
    final_report();
  end
endmodule // tb

bind register_access_command_engine cmd_engine_sva #(.CHANNELS(CHANNELS))
  cmd_engine_sva_i (.ref_clk_in, .arst_n_in, .sclk_in, .cs_n_in, .dout_out,
  .locked_in, .analog_system_config_out, .digital_system_config_out,
  .clock_source_divider_out, .modulator_clock_oversampling_out,
  .channel_enable_out, .channel1_gain_out, .channel2_gain_out,
  .channel3_gain_out, .channel4_gain_out, .foreign_cmd_out,
  .foreign_word_out);
